/* File: pcmpp_pkg.sv */
package pcmpp_pkg;
	// register bus geometry, sample and code widths
	localparam int unsigned ADDR_W           = 3;
	localparam int unsigned DATA_W           = 8;
	localparam int unsigned SAMPLE_W         = 15;
	localparam int unsigned CODE_W           = 8;
	// register offsets
	localparam logic [2:0]  OFS_POWER_CTRL   = 3'h0;
	localparam logic [2:0]  OFS_TX_GAIN      = 3'h1;
	localparam logic [2:0]  OFS_FORMAT       = 3'h2;
	localparam logic [2:0]  OFS_STATUS       = 3'h3;
	localparam logic [2:0]  OFS_TX_HI        = 3'h4;
	localparam logic [2:0]  OFS_TX_LO        = 3'h5;
	localparam logic [2:0]  OFS_RX_HI        = 3'h6;
	localparam logic [2:0]  OFS_RX_LO        = 3'h7;
	// field positions
	localparam int unsigned PWR_UP_BIT       = 0;
	localparam int unsigned DIFF_SEL_BIT     = 1;
	localparam int unsigned STANDBY_BIT      = 7;
	localparam int unsigned FMT_LINEAR_BIT   = 0;
	localparam int unsigned FMT_ALAW_BIT     = 1;
	// values after reset
	localparam logic [7:0]  POWER_CTRL_RST   = 8'h00;
	localparam logic [7:0]  TX_GAIN_RST      = 8'h0b;
	localparam logic [1:0]  FORMAT_RST       = 2'h0;
	// word lengths in bit clocks
	localparam logic [3:0]  LEN_LINEAR       = 4'hf;
	localparam logic [3:0]  LEN_COMPANDED    = 4'h8;
	// master clock loss detection
	localparam int unsigned CLK_MHZ          = 250;
	localparam int unsigned MCLK_TIMEOUT_NS  = 10000;
	localparam int unsigned MCLK_TIMEOUT_CYC = MCLK_TIMEOUT_NS * CLK_MHZ / 1000;
	typedef enum logic [1:0] {
		PCMPP_OFF   = 2'b00,
		PCMPP_ON    = 2'b01,
		PCMPP_DRAIN = 2'b10
	} pcmpp_pwr_e;
endpackage : pcmpp_pkg

/* File: pcmpp_law_if.sv */
`timescale 1ns/1ps
interface pcmpp_law_if;
	import pcmpp_pkg::*;
	logic                alaw;
	logic [SAMPLE_W-1:0] lin_in;
	logic [CODE_W-1:0]   code_out;
	logic [CODE_W-1:0]   code_in;
	logic [SAMPLE_W-1:0] lin_out;
	modport user (output alaw, output lin_in, output code_in,
		input code_out, input lin_out);
	modport law (input alaw, input lin_in, input code_in,
		output code_out, output lin_out);
endinterface : pcmpp_law_if

/* File: pcmpp_law.sv */
`timescale 1ns/1ps
module pcmpp_law (
	pcmpp_law_if.law lw
);
	import pcmpp_pkg::*;
	function automatic logic [7:0] mu_enc(input logic [13:0] s);
		logic [14:0] mag;
		logic [2:0]  seg;
		logic [3:0]  man;
		mag = s[13] ? 15'(15'h0 - {s[13], s}) : {1'b0, s};
		if (mag > 15'h1fde)
			mag = 15'h1fde;
		mag = 15'(mag + 15'h21);
		seg = 3'h0;
		for (int i = 6; i <= 12; i++)
			if (mag[i])
				seg = 3'(i - 5);
		man = 4'(mag >> (32'(seg) + 1));
		return ~{s[13], seg, man};
	endfunction : mu_enc
	function automatic logic [14:0] mu_dec(input logic [7:0] c);
		logic [7:0]  n;
		logic [15:0] t;
		n = ~c;
		t = 16'((({12'h0, n[3:0]} << 3) + 16'h84) << n[6:4]);
		t = 16'(t - 16'h84);
		return n[7] ? 15'(15'h0 - t[15:1]) : t[15:1];
	endfunction : mu_dec
	function automatic logic [7:0] a_enc(input logic [12:0] s);
		logic [12:0] mag;
		logic [2:0]  seg;
		logic [3:0]  man;
		mag = s[12] ? 13'(13'h0 - s) : s;
		if (mag > 13'h0fff)
			mag = 13'h0fff;
		seg = 3'h0;
		for (int i = 5; i <= 11; i++)
			if (mag[i])
				seg = 3'(i - 4);
		man = 4'(mag >> ((seg == 3'h0) ? 1 : 32'(seg)));
		return {~s[12], seg, man} ^ 8'h55;
	endfunction : a_enc
	function automatic logic [14:0] a_dec(input logic [7:0] c);
		logic [7:0]  n;
		logic [15:0] t;
		n = c ^ 8'h55;
		t = {8'h0, n[3:0], 4'h0};
		if (n[6:4] == 3'h0)
			t = 16'(t + 16'h8);
		else
			t = 16'(16'(t + 16'h108) << (n[6:4] - 3'h1));
		return n[7] ? t[15:1] : 15'(15'h0 - t[15:1]);
	endfunction : a_dec
	assign lw.code_out = lw.alaw ? a_enc(lw.lin_in[14:2]) :
		mu_enc(lw.lin_in[14:1]);
	assign lw.lin_out  = lw.alaw ? a_dec(lw.code_in) : mu_dec(lw.code_in);
endmodule : pcmpp_law

/* File: pcmpp_clk_watch.sv */
`timescale 1ns/1ps
module pcmpp_clk_watch #(
	parameter int unsigned TIMEOUT_CYC = pcmpp_pkg::MCLK_TIMEOUT_CYC
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic mclk,
	output logic      active
);
	import pcmpp_pkg::*;
	localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
	logic [2:0]    sync;
	logic [CW-1:0] idle;
	// two-stage sync, third stage for edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sync <= 3'h0;
		else
			sync <= {sync[1:0], mclk};
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle   <= '0;
			active <= 1'b0;
		end else if (sync[2] != sync[1]) begin
			idle   <= '0;
			active <= 1'b1;
		end else if (idle == CW'(TIMEOUT_CYC - 1)) begin
			active <= 1'b0;
		end else begin
			idle <= CW'(idle + 1'b1);
		end
	end
endmodule : pcmpp_clk_watch

/* File: pcmpp_top.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module pcmpp_top #(
	parameter int unsigned MCLK_TIMEOUT = pcmpp_pkg::MCLK_TIMEOUT_CYC
) (
	input  wire logic                            clk,
	input  wire logic                            reset_n,
	input  wire logic                            mclk,
	input  wire logic [pcmpp_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [pcmpp_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                            reg_write,
	input  wire logic                            reg_read,
	output logic      [pcmpp_pkg::DATA_W-1:0]    reg_rdata,
	input  wire logic                            bit_clock,
	input  wire logic                            frame_sync,
	input  wire logic                            serial_sample_in,
	output logic                                 serial_sample_out,
	output logic                                 serial_sample_out_oe,
	output logic                                 differential_earphone_amp,
	output logic                                 single_ended_earphone_amp,
	output logic                                 powered_up,
	output logic                                 standby_low_power
);
	import pcmpp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [7:0]          power_ctrl;
	logic [7:0]          tx_gain;
	logic [1:0]          format;
	logic [6:0]          tx_hi;
	logic [7:0]          tx_lo;
	logic [SAMPLE_W-1:0] rx_sample;
	logic                commit;
	logic [SAMPLE_W-1:0] tx_hold;
	logic                tx_hold_lin;
	logic                tx_toggle;
	logic                mclk_active;
	logic [1:0]          busy_sync;
	logic [1:0]          ack_sync;
	logic [2:0]          rx_tog_sync;
	logic                port_on;
	logic                down_req;
	pcmpp_pwr_e          state;
	pcmpp_pwr_e          next_state;
	// link domain
	logic [1:0]          link_rst_sync;
	logic                link_rst_n;
	logic [1:0]          port_on_sync;
	logic [2:0]          tx_tog_sync;
	logic [SAMPLE_W-1:0] tx_word_l;
	logic                tx_lin_l;
	logic [SAMPLE_W-1:0] tx_sr;
	logic [3:0]          tx_cnt;
	logic [3:0]          len_l;
	logic                fs_prev;
	logic                fs_start;
	logic [SAMPLE_W-1:0] rx_sr;
	logic [3:0]          rx_cnt;
	logic [SAMPLE_W-1:0] rx_word_l;
	logic                rx_toggle;

	pcmpp_law_if law_bus ();

	////////////////////////////////////////////////////////////////////////
	// master clock activity
	pcmpp_clk_watch #(
		.TIMEOUT_CYC (MCLK_TIMEOUT)
	) u_watch (
		.clk     (clk),
		.reset_n (reset_n),
		.mclk    (mclk),
		.active  (mclk_active)
	);

	////////////////////////////////////////////////////////////////////////
	// companding
	// law codec
	pcmpp_law u_law (
		.lw (law_bus.law)
	);
	assign law_bus.alaw    = format[FMT_ALAW_BIT];
	assign law_bus.lin_in  = {tx_hi, tx_lo};
	assign law_bus.code_in = rx_word_l[CODE_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// control registers
	// reset defaults
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			power_ctrl <= POWER_CTRL_RST;
			tx_gain    <= TX_GAIN_RST;
			format     <= FORMAT_RST;
		end else if (reg_write) begin
			case (reg_addr)
				OFS_POWER_CTRL: power_ctrl <= reg_wdata;
				OFS_TX_GAIN:    tx_gain    <= reg_wdata;
				OFS_FORMAT:     format     <= reg_wdata[1:0];
				default:        ;
			endcase
		end
	end

	// transmit sample, committed by the low byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_hi  <= 7'h00;
			tx_lo  <= 8'h00;
			commit <= 1'b0;
		end else begin
			commit <= reg_write && reg_addr == OFS_TX_LO;
			if (reg_write && reg_addr == OFS_TX_HI)
				tx_hi <= reg_wdata[6:0];
			if (reg_write && reg_addr == OFS_TX_LO)
				tx_lo <= reg_wdata;
		end
	end

	// hold word handed to the link with a toggle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_hold     <= '0;
			tx_hold_lin <= 1'b0;
			tx_toggle   <= 1'b0;
		end else if (commit) begin
			if (format[FMT_LINEAR_BIT])
				tx_hold <= {tx_hi, tx_lo};
			else
				tx_hold <= {law_bus.code_out, 7'h00};
			tx_hold_lin <= format[FMT_LINEAR_BIT];
			tx_toggle   <= ~tx_toggle;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossings into the register clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_sync   <= 2'h0;
			ack_sync    <= 2'h0;
			rx_tog_sync <= 3'h0;
		end else begin
			busy_sync   <= {busy_sync[0], serial_sample_out_oe};
			ack_sync    <= {ack_sync[0], port_on_sync[1]};
			rx_tog_sync <= {rx_tog_sync[1:0], rx_toggle};
		end
	end

	// received word, decoded in companded mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rx_sample <= '0;
		else if (rx_tog_sync[2] != rx_tog_sync[1])
			rx_sample <= format[FMT_LINEAR_BIT] ? rx_word_l :
				law_bus.lin_out;
	end

	////////////////////////////////////////////////////////////////////////
	// power sequencing
	// power bit, or master clock loss while the standby bit is clear
	assign down_req = !power_ctrl[PWR_UP_BIT] ||
		(!tx_gain[STANDBY_BIT] && !mclk_active);

	always_comb begin
		next_state = state;
		case (state)
			PCMPP_OFF: begin
				if (!down_req)
					next_state = PCMPP_ON;
			end
			PCMPP_ON: begin
				if (down_req)
					next_state = PCMPP_DRAIN;
			end
			PCMPP_DRAIN: begin
				if (!down_req)
					next_state = PCMPP_ON;
				else if (!busy_sync[1] && !ack_sync[1])
					next_state = PCMPP_OFF;
			end
			default: next_state = PCMPP_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			state <= PCMPP_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			differential_earphone_amp <= 1'b0;
			single_ended_earphone_amp <= 1'b0;
			powered_up                <= 1'b0;
			standby_low_power         <= 1'b0;
			port_on                   <= 1'b0;
		end else begin
			differential_earphone_amp <= next_state == PCMPP_ON &&
				power_ctrl[DIFF_SEL_BIT];
			single_ended_earphone_amp <= next_state == PCMPP_ON &&
				!power_ctrl[DIFF_SEL_BIT];
			powered_up                <= next_state != PCMPP_OFF;
			standby_low_power         <= next_state == PCMPP_OFF &&
				tx_gain[STANDBY_BIT];
			port_on                   <= next_state == PCMPP_ON;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read, data in the following cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				OFS_POWER_CTRL: reg_rdata <= power_ctrl;
				OFS_TX_GAIN:    reg_rdata <= tx_gain;
				OFS_FORMAT:     reg_rdata <= {6'h00, format};
				OFS_STATUS:     reg_rdata <= {3'h0,
					single_ended_earphone_amp, differential_earphone_amp,
					busy_sync[1], mclk_active, powered_up};
				OFS_TX_HI:      reg_rdata <= {1'b0, tx_hi};
				OFS_TX_LO:      reg_rdata <= tx_lo;
				OFS_RX_HI:      reg_rdata <= {1'b0, rx_sample[14:8]};
				OFS_RX_LO:      reg_rdata <= rx_sample[7:0];
				default:        reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain reset and crossings
	always_ff @(posedge bit_clock or negedge reset_n) begin
		if (!reset_n)
			link_rst_sync <= 2'h0;
		else
			link_rst_sync <= {link_rst_sync[0], 1'b1};
	end
	assign link_rst_n = link_rst_sync[1];

	always_ff @(posedge bit_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			port_on_sync <= 2'h0;
			tx_tog_sync  <= 3'h0;
		end else begin
			port_on_sync <= {port_on_sync[0], port_on};
			tx_tog_sync  <= {tx_tog_sync[1:0], tx_toggle};
		end
	end

	always_ff @(posedge bit_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_word_l <= '0;
			tx_lin_l  <= 1'b0;
		end else if (tx_tog_sync[2] != tx_tog_sync[1]) begin
			tx_word_l <= tx_hold;
			tx_lin_l  <= tx_hold_lin;
		end
	end

	assign len_l = tx_lin_l ? LEN_LINEAR : LEN_COMPANDED;

	////////////////////////////////////////////////////////////////////////
	// frame sync, taken on the falling edge
	always_ff @(negedge bit_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fs_prev  <= 1'b0;
			fs_start <= 1'b0;
		end else begin
			fs_prev  <= frame_sync;
			fs_start <= frame_sync && !fs_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit shifter
	// launch on rise
	always_ff @(posedge bit_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_sr                <= '0;
			tx_cnt               <= 4'h0;
			serial_sample_out    <= 1'b0;
			serial_sample_out_oe <= 1'b0;
		end else if (fs_start && port_on_sync[1] &&
			!serial_sample_out_oe) begin
			serial_sample_out    <= tx_word_l[14];
			tx_sr                <= {tx_word_l[13:0], 1'b0};
			tx_cnt               <= 4'h1;
			serial_sample_out_oe <= 1'b1;
		end else if (serial_sample_out_oe) begin
			if (tx_cnt == len_l) begin
				serial_sample_out    <= 1'b0;
				serial_sample_out_oe <= 1'b0;
			end else begin
				serial_sample_out <= tx_sr[14];
				tx_sr             <= {tx_sr[13:0], 1'b0};
				tx_cnt            <= 4'(tx_cnt + 4'h1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive shifter
	// sample on fall
	always_ff @(negedge bit_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_sr     <= '0;
			rx_cnt    <= 4'h0;
			rx_word_l <= '0;
			rx_toggle <= 1'b0;
		end else if (fs_start && port_on_sync[1] && rx_cnt == 4'h0) begin
			rx_sr  <= {14'h0, serial_sample_in};
			rx_cnt <= 4'h1;
		end else if (rx_cnt != 4'h0) begin
			rx_sr <= {rx_sr[13:0], serial_sample_in};
			if (rx_cnt == 4'(len_l - 4'h1)) begin
				rx_cnt    <= 4'h0;
				rx_word_l <= {rx_sr[13:0], serial_sample_in};
				rx_toggle <= ~rx_toggle;
			end else begin
				rx_cnt <= 4'(rx_cnt + 4'h1);
			end
		end
	end
endmodule : pcmpp_top

/* File: pcmpp_top_chk.sv */
`timescale 1ns/1ps
module pcmpp_top_chk #(
	parameter int unsigned MCLK_TIMEOUT = 20
) (
	input wire logic                         clk,
	input wire logic                         reset_n,
	input wire logic [pcmpp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pcmpp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                         reg_write,
	input wire logic                         reg_read,
	input wire logic [pcmpp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                         bit_clock,
	input wire logic                         frame_sync,
	input wire logic                         serial_sample_out,
	input wire logic                         serial_sample_out_oe,
	input wire logic                         differential_earphone_amp,
	input wire logic                         single_ended_earphone_amp,
	input wire logic                         powered_up,
	input wire logic                         standby_low_power
);
	import pcmpp_pkg::*;
	logic [4:0] run;
	logic       fs_q;
	logic       fs_p;
	logic       start_seen;
	////////////////////////////////
	// length of each driven word
	always_ff @(posedge bit_clock or negedge reset_n) begin
		if (!reset_n) run <= 5'h00;
		else run <= serial_sample_out_oe ? run + 5'h01 : 5'h00;
	end
	always_ff @(negedge bit_clock or negedge reset_n) begin
		if (!reset_n) begin
			fs_q <= 1'b0;
			fs_p <= 1'b0;
		end else begin
			fs_q <= frame_sync;
			fs_p <= fs_q;
		end
	end
	assign start_seen = fs_q & ~fs_p;
	sequence s_wr_ctrl;
		reg_write && reg_addr == OFS_POWER_CTRL;
	endsequence
	sequence s_rd_ctrl;
		reg_read && reg_addr == OFS_POWER_CTRL;
	endsequence
	////////////////////////////////
	a_reset_quiet: assert property (@(posedge clk)
		disable iff (!reset_n)
		$rose(reset_n) |-> !powered_up && !standby_low_power)
		else $error("outputs not quiet after reset");
	a_ctrl_readback: assert property (@(posedge clk)
		disable iff (!reset_n)
		s_wr_ctrl ##2 s_rd_ctrl |=> reg_rdata == $past(reg_wdata, 3))
		else $error("power control readback wrong");
	a_rdata_idle: assert property (@(posedge clk)
		disable iff (!reset_n) !reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_amp_onehot: assert property (@(posedge clk)
		disable iff (!reset_n)
		!(differential_earphone_amp && single_ended_earphone_amp))
		else $error("both earphone amps on");
	a_amp_powered: assert property (@(posedge clk)
		disable iff (!reset_n)
		differential_earphone_amp || single_ended_earphone_amp |-> powered_up)
		else $error("amp on while powered down");
	a_stby_off: assert property (@(posedge clk)
		disable iff (!reset_n) standby_low_power |-> !powered_up)
		else $error("standby while powered");
	a_word_len: assert property (@(posedge bit_clock)
		disable iff (!reset_n)
		$fell(serial_sample_out_oe) |-> run == 5'h08 || run == 5'h0f)
		else $error("word length not 8 or 15");
	a_word_start: assert property (@(posedge bit_clock)
		disable iff (!reset_n)
		$rose(serial_sample_out_oe) |-> $past(start_seen))
		else $error("word started without frame sync");
	a_idle_low: assert property (@(posedge bit_clock)
		disable iff (!reset_n) !serial_sample_out_oe |-> !serial_sample_out)
		else $error("data driven while released");
endmodule : pcmpp_top_chk

/* File: pcmpp_host_model.sv */
`timescale 1ns/1ps
module pcmpp_host_model (
	output logic      bit_clock,
	output logic      frame_sync,
	output logic      serial_sample_in,
	input  wire logic serial_sample_out,
	input  wire logic serial_sample_out_oe
);
	initial begin
		bit_clock = 1'b0;
		frame_sync = 1'b0;
		serial_sample_in = 1'b0;
	end
	task automatic frame(input logic [14:0] rx, input int n, input bit chk,
		output logic [14:0] tx, output int bad);
		tx = 15'h0000;
		bad = 0;
		for (int c = 0; c < 16; c++) begin
			bit_clock = 1'b1;
			frame_sync = (c == 0);
			if (c >= 1 && c <= n) serial_sample_in = rx[n-c];
			else serial_sample_in = ~serial_sample_in;
			#7.5;
			if (c >= 1 && c <= n) tx[n-c] = serial_sample_out;
			if (chk && serial_sample_out_oe !== (c >= 1 && c <= n)) bad++;
			bit_clock = 1'b0;
			#7.5;
		end
	endtask : frame
endmodule : pcmpp_host_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import pcmpp_pkg::*;
	typedef struct {
		logic [7:0]  pc, tg, fmt;
		logic [14:0] tx, rx;
		int          n;
		logic [14:0] etx;
		logic [3:0]  outs;
		logic [14:0] erx;
	} pcmpp_row_s;
	pcmpp_row_s rows [6] = '{
		'{8'h03, 8'h0b, 8'h01, 15'h5a3c, 15'h2b71, 15, 15'h5a3c, 4'hc,
			15'h2b71},
		'{8'h01, 8'h0b, 8'h01, 15'h4001, 15'h7ffe, 15, 15'h4001, 4'ha,
			15'h7ffe},
		'{8'h01, 8'h0b, 8'h00, 15'h0000, 15'h00a5, 8, 15'h00ff, 4'ha,
			15'h0cfe},
		'{8'h03, 8'h0b, 8'h02, 15'h0000, 15'h005a, 8, 15'h00d5, 4'hc,
			15'h7f84},
		'{8'h00, 8'h8b, 8'h01, 15'h1234, 15'h0000, 0, 15'h0000, 4'h1,
			15'h0000},
		'{8'h00, 8'h0b, 8'h01, 15'h1234, 15'h0000, 0, 15'h0000, 4'h0,
			15'h0000}};
	logic       clk, bit_clock, frame_sync, ssi, sso, oe;
	logic       dif_amp, se_amp, pwr_up, stby;
	logic       reset_n = 1'b0;
	logic       mclk = 1'b0;
	logic       mclk_run = 1'b1;
	logic       reg_write = 1'b0;
	logic       reg_read = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	int         fails = 0;
	int         total_checks = 0;
	int         cycles = 0;
	pcmpp_top #(.MCLK_TIMEOUT(20)) u_dut (.clk(clk), .reset_n(reset_n),
		.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.bit_clock(bit_clock), .frame_sync(frame_sync),
		.serial_sample_in(ssi), .serial_sample_out(sso),
		.serial_sample_out_oe(oe), .differential_earphone_amp(dif_amp),
		.single_ended_earphone_amp(se_amp), .powered_up(pwr_up),
		.standby_low_power(stby));
	pcmpp_host_model u_host (.bit_clock(bit_clock), .frame_sync(frame_sync),
		.serial_sample_in(ssi), .serial_sample_out(sso),
		.serial_sample_out_oe(oe));
	////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mclk_run) mclk <= ~mclk;
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			fails++;
			final_report();
		end
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic chk(input string nm, input logic [14:0] e,
		input logic [14:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [14:0] outs();
		return {11'h000, pwr_up, dif_amp, se_amp, stby};
	endfunction : outs
	task automatic chk_defaults();
		logic [7:0] v;
		rd(OFS_POWER_CTRL, v);
		chk("power_ctrl", {7'h00, POWER_CTRL_RST}, {7'h00, v});
		rd(OFS_TX_GAIN, v);
		chk("tx_gain", {7'h00, TX_GAIN_RST}, {7'h00, v});
		rd(OFS_FORMAT, v);
		chk("format", {13'h0000, FORMAT_RST}, {7'h00, v});
		chk("outs", 15'h0000, outs());
	endtask : chk_defaults
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	////////////////////////////////
	initial begin
		logic [7:0]  v, h;
		logic [14:0] tx;
		int          bad;
		repeat (125) @(posedge clk);
		reset_n <= 1'b1;
		chk_defaults();
		foreach (rows[i]) begin
			wr(OFS_POWER_CTRL, 8'h00);
			wr(OFS_TX_GAIN, rows[i].tg);
			wr(OFS_FORMAT, rows[i].fmt);
			wr(OFS_TX_HI, {1'b0, rows[i].tx[14:8]});
			wr(OFS_TX_LO, rows[i].tx[7:0]);
			wr(OFS_POWER_CTRL, rows[i].pc);
			rd(OFS_POWER_CTRL, v);
			chk("power_ctrl", {7'h00, rows[i].pc}, {7'h00, v});
			u_host.frame(rows[i].rx, rows[i].n, 1'b0, tx, bad);
			u_host.frame(rows[i].rx, rows[i].n, 1'b1, tx, bad);
			chk("tx_word", rows[i].etx, tx);
			chk("oe_cycles", 15'h0000, 15'(bad));
			repeat (10) @(posedge clk);
			chk("outs", {11'h000, rows[i].outs}, outs());
			rd(OFS_RX_HI, h);
			rd(OFS_RX_LO, v);
			if (rows[i].n != 0)
				chk("rx_word", rows[i].erx, {h[6:0], v});
		end
		wr(OFS_TX_HI, 8'h6b);
		wr(OFS_TX_LO, 8'h2d);
		wr(OFS_POWER_CTRL, 8'h01);
		u_host.frame(15'h0000, 15, 1'b0, tx, bad);
		fork
			u_host.frame(15'h0000, 15, 1'b1, tx, bad);
			begin
				repeat (20) @(posedge clk);
				wr(OFS_POWER_CTRL, 8'h00);
			end
		join
		chk("drain_word", 15'h6b2d, tx);
		chk("oe_cycles", 15'h0000, 15'(bad));
		u_host.frame(15'h0000, 0, 1'b0, tx, bad);
		u_host.frame(15'h0000, 0, 1'b1, tx, bad);
		chk("oe_cycles", 15'h0000, 15'(bad));
		chk("outs", 15'h0000, outs());
		wr(OFS_POWER_CTRL, 8'h01);
		mclk_run <= 1'b0;
		repeat (60) @(posedge clk);
		chk("outs", 15'h0000, outs());
		u_host.frame(15'h0000, 0, 1'b1, tx, bad);
		chk("oe_cycles", 15'h0000, 15'(bad));
		wr(OFS_TX_GAIN, 8'h8b);
		repeat (10) @(posedge clk);
		chk("outs", 15'h000a, outs());
		mclk_run <= 1'b1;
		reset_n <= 1'b0;
		repeat (125) @(posedge clk);
		reset_n <= 1'b1;
		chk_defaults();
		final_report();
	end
endmodule : tb_top
bind pcmpp_top pcmpp_top_chk #(.MCLK_TIMEOUT(MCLK_TIMEOUT)) u_chk (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .bit_clock(bit_clock), .frame_sync(frame_sync),
	.serial_sample_out(serial_sample_out),
	.serial_sample_out_oe(serial_sample_out_oe),
	.differential_earphone_amp(differential_earphone_amp),
	.single_ended_earphone_amp(single_ended_earphone_amp),
	.powered_up(powered_up), .standby_low_power(standby_low_power));
